/* File: bench/tb_wdt_ch1.sv */
// Self-checking testbench for the second watchdog channel
`timescale 1ns/100ps
`default_nettype none
module tb_wdt_ch1;
    typedef struct packed {logic [7:0] lo; logic [7:0] hi;} exp_t;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic pin_reset_req = 1'b0;
    logic sub_clk, external_reset_pin, reset_output_pin_q, chip_reset_q;
    logic nmi_req_q, interval_timer_irq_q, reset_source_bit_q, rd_pend = 1'b0;
    logic [7:0] rdata_q, start;
    wdt_ch1_pkg::bus_req_t bus = '0;
    exp_t exp_q[$];
    exp_t mon_e;
    logic in_range;
    int miscompares = 0, num_checks = 0, cycles = 0, seed = 32'h5595, n, m, div;
    int mdiv[4] = '{2, 64, 128, 512};

    always #4 clock = ~clock;

    wdt_ch1 dut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .bus(bus),
        .sub_clk(sub_clk), .external_reset_pin(external_reset_pin), .rdata_q(rdata_q),
        .reset_output_pin_q(reset_output_pin_q), .chip_reset_q(chip_reset_q),
        .nmi_req_q(nmi_req_q), .interval_timer_irq_q(interval_timer_irq_q),
        .reset_source_bit_q(reset_source_bit_q));
    wdt_far_side far (.pin_reset_req(pin_reset_req), .sub_clk(sub_clk),
        .external_reset_pin(external_reset_pin));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task final_report;
        if (miscompares == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Called just after an edge; an idle edge follows so calls can chain
    task automatic wr(input logic [15:0] w, input logic byt = 1'b0);
        bus.wr_word = 1'b1;
        bus.wr_byte = byt;
        bus.wdata = w;
        @(posedge clock);
        #1 bus.wr_word = 1'b0;
        bus.wr_byte = 1'b0;
        @(posedge clock);
        #1;
    endtask

    task automatic rd(input logic csr, input logic [7:0] lo, input logic [7:0] hi);
        bus.rd_csr = csr;
        bus.rd_cnt = !csr;
        exp_q.push_back({lo, hi});
        @(posedge clock);
        #1 bus.rd_csr = 1'b0;
        bus.rd_cnt = 1'b0;
        @(posedge clock);
        #1;
    endtask

    // Bounded waits; a missed event shows up in the checks that follow
    task automatic wait_irq;
        repeat (1200) if (interval_timer_irq_q !== 1'b1) @(posedge clock);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clock) begin
        if (rd_pend) begin
            mon_e = exp_q.pop_front();
            in_range = rdata_q >= mon_e.lo && rdata_q <= mon_e.hi;
            check("rdata range", {15'h0000, in_range}, 16'h0001);
        end
        rd_pend <= bus.rd_csr | bus.rd_cnt;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clock);
        #1 rst_n = 1'b1;
        rd(1'b1, 8'h00, 8'h00);
        rd(1'b0, 8'h00, 8'h00);
        // Keyed and refused writes
        wr(16'hA5_27);
        wr(16'h5A_FE);
        wr(16'h5A_11, 1'b1);
        wr(16'h3C_11);
        rd(1'b0, 8'hFE, 8'hFE);
        // Interval overflow, flag clearing protocol
        wr(16'hA5_20);
        wr(16'h5A_FE);
        wait_irq();
        check("irq", {15'h0000, interval_timer_irq_q}, 16'h0001);
        wr(16'hA5_20);
        rd(1'b1, 8'hA0, 8'hA0);
        wr(16'hA5_A0);
        rd(1'b1, 8'hA0, 8'hA0);
        rd(1'b1, 8'hA0, 8'hA0);
        wr(16'hA5_20);
        rd(1'b1, 8'h20, 8'h20);
        check("irq clear", {15'h0000, interval_timer_irq_q}, 16'h0000);
        wait_irq();
        wr(16'hA5_00);
        rd(1'b1, 8'h00, 8'h00);
        rd(1'b0, 8'h00, 8'h00);
        // Watchdog NMI: one pulse, pin stays high
        wr(16'hA5_60);
        wr(16'h5A_FE);
        n = 0;
        m = 0;
        repeat (20) begin
            @(posedge clock);
            #1 n += nmi_req_q;
            m += !reset_output_pin_q;
        end
        check("nmi pulses", 16'(n), 16'h0001);
        check("pin low", 16'(m), 16'h0000);
        // Regular reloads keep the watchdog from ever wrapping
        n = 0;
        repeat (4) begin
            wr(16'h5A_00);
            repeat (400) begin
                @(posedge clock);
                #1 n += nmi_req_q;
            end
        end
        check("nmi kicked", 16'(n), 16'h0000);
        // Watchdog reset lengths
        wr(16'hA5_69);
        wr(16'h5A_FE);
        n = 0;
        while (chip_reset_q !== 1'b1 && n < 300) begin
            @(posedge clock);
            #1 n++;
        end
        n = 0;
        m = 0;
        while (chip_reset_q === 1'b1 && n < 700) begin
            n++;
            m += !reset_output_pin_q;
            @(posedge clock);
            #1;
        end
        check("reset len", 16'(n), 16'h0206);
        check("pin len", 16'(m), 16'h0084);
        rd(1'b1, 8'h69, 8'h69);
        check("source", {15'h0000, reset_source_bit_q}, 16'h0000);
        pin_reset_req = 1'b1;
        repeat (5) @(posedge clock);
        #1 pin_reset_req = 1'b0;
        check("source pin", {15'h0000, reset_source_bit_q}, 16'h0001);
        // Main divisors; lost increment on the write edge keeps the count exact
        for (int c = 0; c < 4; c++) begin
            wr(16'hA5_20 | 16'(c));
            start = 8'($random(seed)) & 8'h7F;
            wr({8'h5A, start});
            repeat (mdiv[c] * 3 - 1) @(posedge clock);
            #1 rd(1'b0, start + 8'h03, start + 8'h03);
        end
        // Frozen clock enable: only the edge after the write may count
        wr(16'hA5_20);
        wr(16'h5A_40);
        clk_en = 1'b0;
        repeat (40) @(posedge clock);
        #1 clk_en = 1'b1;
        rd(1'b0, 8'h40, 8'h41);
        // Sub-clock divisors, asynchronous so one count of slack
        for (int c = 0; c < 8; c++) begin
            div = (c == 4) ? 32 : (2 << c);
            wr(16'hA5_00);
            wr(16'hA5_30 | 16'(c));
            wr(16'h5A_00);
            repeat (div * 48) @(posedge clock);
            #1 rd(1'b0, 8'h03, 8'h05);
        end
        wr(16'hA5_00);
        repeat (3) @(posedge clock);
        final_report();
    end
endmodule // tb_wdt_ch1
`default_nettype wire

/* File: bench/wdt_far_side.sv */
// Far-side model: sub-clock oscillator and external reset pin source
`timescale 1ns/100ps
`default_nettype none
module wdt_far_side (
    input wire logic pin_reset_req,
    output logic sub_clk,
    output logic external_reset_pin
);
    // Runs free like a crystal, phase unrelated to the system clock
    initial sub_clk = 1'b0;
    always #48.3 sub_clk = ~sub_clk;
    // Only the reset pin is modelled; no NMI pin source competes
    assign external_reset_pin = ~pin_reset_req;
endmodule // wdt_far_side
`default_nettype wire

/* File: rtl/wdt_ch1.sv */
// Watchdog / interval timer, channel with prescaler select
`timescale 1ns/100ps
`default_nettype none
module wdt_ch1 (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire wdt_ch1_pkg::bus_req_t bus,
    input wire logic sub_clk,
    input wire logic external_reset_pin,
    output logic [7:0] rdata_q,
    output logic reset_output_pin_q,
    output logic chip_reset_q,
    output logic nmi_req_q,
    output logic interval_timer_irq_q,
    output logic reset_source_bit_q
);
    ////////////////////////////////////////////////////////////////////////
    // Divider select: bits of prescaler that must be all ones for a tick
    function automatic logic [4:0] main_exp(input logic [2:0] cks);
        case (cks)
            3'h0: main_exp = 5'h01;
            3'h1: main_exp = 5'h06;
            3'h2: main_exp = 5'h07;
            3'h3: main_exp = 5'h09;
            3'h4: main_exp = 5'h0B;
            3'h5: main_exp = 5'h0D;
            3'h6: main_exp = 5'h0F;
            default: main_exp = 5'h11;
        endcase
    endfunction

    function automatic logic [16:0] low_mask(input logic [4:0] e);
        low_mask = 17'((18'h00001 << e) - 18'h00001);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] csr_q, csr_d;
    logic [7:0] cnt_q, cnt_d;
    logic armed_q, armed_d;
    logic [16:0] main_psc_q;
    logic [7:0] sub_psc_q;
    logic [2:0] sub_sync_q;
    logic [1:0] ext_sync_q;
    logic [9:0] rst_cnt_q;
    logic [7:0] pin_cnt_q;

    wire logic wr_ok = bus.wr_word && !bus.wr_byte;
    wire logic wr_cnt = wr_ok && bus.wdata[15:8] == wdt_ch1_pkg::KEY_COUNTER;
    wire logic wr_csr = wr_ok && bus.wdata[15:8] == wdt_ch1_pkg::KEY_CONTROL;
    wire logic [7:0] wd = bus.wdata[7:0];
    wire logic count_en = csr_q[wdt_ch1_pkg::ENABLE_BIT];
    wire logic mode_wd = csr_q[wdt_ch1_pkg::MODE_BIT];
    wire logic sel_rst = csr_q[wdt_ch1_pkg::RST_NMI_BIT];
    wire logic [2:0] cks = csr_q[wdt_ch1_pkg::CKS_MSB:0];
    // Code 100 on the sub-clock side follows the binary progression
    wire logic [4:0] sub_e = 5'({2'h0, cks} + 5'h01);
    wire logic sub_edge = sub_sync_q[1] && !sub_sync_q[2];
    wire logic main_tick =
        (main_psc_q & low_mask(main_exp(cks))) == low_mask(main_exp(cks));
    wire logic sub_tick = sub_edge &&
        ((17'(sub_psc_q) & low_mask(sub_e)) == low_mask(sub_e));
    wire logic tick = count_en &&
        (csr_q[wdt_ch1_pkg::PSC_SEL_BIT] ? sub_tick : main_tick);
    // A coinciding counter write swallows the increment
    wire logic wrap_event = tick && !wr_cnt && cnt_q == wdt_ch1_pkg::CNT_MAX;
    wire logic wd_rst_event = wrap_event && mode_wd && sel_rst;
    wire logic reset_end = chip_reset_q && rst_cnt_q == 10'h001;
    wire logic ext_low = !ext_sync_q[1];

    ////////////////////////////////////////////////////////////////////////
    // Next state of control register, flag and counter
    always_comb begin
        csr_d = csr_q;
        armed_d = armed_q;
        cnt_d = cnt_q;
        if (bus.rd_csr && csr_q[wdt_ch1_pkg::FLAG_BIT]) begin
            armed_d = 1'b1;
        end
        if (wr_csr) begin
            csr_d[6:0] = wd[6:0];
            if (!wd[wdt_ch1_pkg::FLAG_BIT] && armed_q) begin
                csr_d[wdt_ch1_pkg::FLAG_BIT] = 1'b0;
            end
            if (!wd[wdt_ch1_pkg::ENABLE_BIT]) begin
                csr_d[wdt_ch1_pkg::FLAG_BIT] = 1'b0;
            end
            armed_d = 1'b0;
        end
        // A stale arm must not let a later flag clear unread
        if (reset_end) begin
            csr_d[wdt_ch1_pkg::FLAG_BIT] = 1'b0;
            armed_d = 1'b0;
        end
        // Set beats any clear in the same cycle
        if (wrap_event) begin
            csr_d[wdt_ch1_pkg::FLAG_BIT] = 1'b1;
        end
        if (wr_cnt) begin
            cnt_d = wd;
        end else if (!count_en) begin
            cnt_d = wdt_ch1_pkg::CNT_RESET;
        end else if (tick) begin
            cnt_d = 8'(cnt_q + 8'h01);
        end
        if (wr_csr && !wd[wdt_ch1_pkg::ENABLE_BIT]) begin
            cnt_d = wdt_ch1_pkg::CNT_RESET;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            csr_q <= wdt_ch1_pkg::CSR_RESET;
            cnt_q <= wdt_ch1_pkg::CNT_RESET;
            armed_q <= 1'b0;
            interval_timer_irq_q <= 1'b0;
        end else if (clk_en) begin
            csr_q <= csr_d;
            cnt_q <= cnt_d;
            armed_q <= armed_d;
            interval_timer_irq_q <= csr_d[wdt_ch1_pkg::FLAG_BIT] &&
                !csr_d[wdt_ch1_pkg::MODE_BIT];
        end
    end

    // Prescalers run free; the sub-clock pin is synchronised first
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            main_psc_q <= '0;
            sub_psc_q <= '0;
            sub_sync_q <= '0;
            ext_sync_q <= 2'h3;
        end else if (clk_en) begin
            main_psc_q <= 17'(main_psc_q + 17'h00001);
            sub_sync_q <= {sub_sync_q[1:0], sub_clk};
            ext_sync_q <= {ext_sync_q[0], external_reset_pin};
            if (sub_edge) begin
                sub_psc_q <= 8'(sub_psc_q + 8'h01);
            end
        end
    end

    // Internal reset, pin pulse and NMI request
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_cnt_q <= '0;
            pin_cnt_q <= '0;
            chip_reset_q <= 1'b0;
            reset_output_pin_q <= 1'b1;
            nmi_req_q <= 1'b0;
            reset_source_bit_q <= 1'b0;
        end else if (clk_en) begin
            nmi_req_q <= wrap_event && mode_wd && !sel_rst;
            if (wd_rst_event && !chip_reset_q) begin
                rst_cnt_q <= wdt_ch1_pkg::RESET_CNT_LOAD;
                pin_cnt_q <= wdt_ch1_pkg::PIN_CNT_LOAD;
                chip_reset_q <= 1'b1;
                reset_output_pin_q <= 1'b0;
            end else begin
                if (chip_reset_q) begin
                    rst_cnt_q <= 10'(rst_cnt_q - 10'h001);
                    chip_reset_q <= !reset_end;
                end
                if (!reset_output_pin_q) begin
                    pin_cnt_q <= 8'(pin_cnt_q - 8'h01);
                    reset_output_pin_q <= pin_cnt_q == 8'h01;
                end
            end
            if (ext_low) begin
                reset_source_bit_q <= 1'b1;
            end else if (wd_rst_event && !chip_reset_q) begin
                reset_source_bit_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (clk_en) begin
            if (bus.rd_csr) begin
                rdata_q <= csr_q;
            end else if (bus.rd_cnt) begin
                rdata_q <= cnt_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    logic [9:0] hold_q;
    logic [7:0] low_q;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hold_q <= '0;
            low_q <= '0;
        end else if (clk_en) begin
            hold_q <= chip_reset_q ? 10'(hold_q + 10'h001) : 10'h000;
            low_q <= !reset_output_pin_q ? 8'(low_q + 8'h01) : 8'h00;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_wrap_set;
        clk_en && wrap_event |=> csr_q[7] && cnt_q == 8'h00;
    endproperty
    a_wrap_set: assert property (p_wrap_set) else $error("flag not set on wrap");
    property p_one_keeps;
        clk_en && wr_csr && wd[7] && wd[5] && csr_q[7] && !reset_end |=> csr_q[7];
    endproperty
    a_one_keeps: assert property (p_one_keeps) else $error("write 1 cleared flag");
    property p_needs_read;
        clk_en && wr_csr && !armed_q && wd[5] && csr_q[7] && !reset_end |=> csr_q[7];
    endproperty
    a_needs_read: assert property (p_needs_read) else $error("flag cleared unread");
    // A wrap in the same cycle sets the flag, so it is left out here
    property p_en_clear;
        clk_en && wr_csr && !wd[5] && !wrap_event
            |=> !csr_q[7] && cnt_q == 8'h00 && !count_en;
    endproperty
    a_en_clear: assert property (p_en_clear) else $error("enable clear failed");
    property p_write_wins;
        clk_en && wr_cnt |=> cnt_q == $past(bus.wdata[7:0]);
    endproperty
    a_write_wins: assert property (p_write_wins) else $error("counter write lost");
    property p_reset_len;
        clk_en && $fell(chip_reset_q) |-> hold_q == 10'(wdt_ch1_pkg::RESET_CYCLES);
    endproperty
    a_reset_len: assert property (p_reset_len) else $error("reset length wrong");
    property p_pin_len;
        clk_en && $rose(reset_output_pin_q)
            |-> low_q == 8'(wdt_ch1_pkg::PIN_LOW_CYCLES) && chip_reset_q;
    endproperty
    a_pin_len: assert property (p_pin_len) else $error("pin pulse length wrong");
    property p_nmi;
        clk_en && wrap_event && mode_wd && !sel_rst && reset_output_pin_q
            |=> nmi_req_q && reset_output_pin_q;
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi action wrong");
    property p_irq;
        $rose(csr_q[7]) && !mode_wd |-> interval_timer_irq_q;
    endproperty
    a_irq: assert property (p_irq) else $error("interval irq late");
    property p_src;
        clk_en && ext_low |=> reset_source_bit_q;
    endproperty
    a_src: assert property (p_src) else $error("pin reset lost priority");
    property p_rst_clears;
        clk_en && reset_end && !wrap_event |=> !csr_q[7];
    endproperty
    a_rst_clears: assert property (p_rst_clears) else $error("reset left flag");
endmodule // wdt_ch1
`default_nettype wire

/* File: rtl/wdt_ch1_pkg.sv */
// Constants and carrier types for the second watchdog channel
`default_nettype none
package wdt_ch1_pkg;
    localparam int FLAG_BIT = 7;
    localparam int MODE_BIT = 6;
    localparam int ENABLE_BIT = 5;
    localparam int PSC_SEL_BIT = 4;
    localparam int RST_NMI_BIT = 3;
    localparam int CKS_MSB = 2;
    localparam logic [7:0] CSR_RESET = 8'h00;
    localparam logic [7:0] CNT_RESET = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] KEY_COUNTER = 8'h5A;
    localparam logic [7:0] KEY_CONTROL = 8'hA5;
    localparam int MAIN_PSC_W = 17;
    localparam int SUB_PSC_W = 8;
    // Internal reset and pin pulse lengths, in system clocks
    localparam int RESET_CYCLES = 518;
    localparam int PIN_LOW_CYCLES = 132;
    localparam logic [9:0] RESET_CNT_LOAD = 10'(RESET_CYCLES);
    localparam logic [7:0] PIN_CNT_LOAD = 8'(PIN_LOW_CYCLES);

    typedef struct packed {
        logic rd_csr;
        logic rd_cnt;
        logic wr_word;
        logic wr_byte;
        logic [15:0] wdata;
    } bus_req_t;
endpackage
`default_nettype wire
